// >>> rtl/anw_pkg.sv
// Constants shared by the converter nibble link, the converter model and the bench.
package anw_pkg;

   // ==========================================================================
   // Word and frame geometry
   // ==========================================================================
   localparam int          WORD_W      = 16;   // Sample word width.
   localparam int          NIB_W       = 4;    // Data lines per direction.
   localparam int          SLOTS       = 4;    // Slots in one word frame.
   localparam int          SLOT_W      = 2;    // Width of the slot counter.
   localparam logic [1:0]  SLOT_FIRST  = 2'h0; // Slot that the strobe marks.
   localparam logic [1:0]  SLOT_LAST   = 2'h3; // Slot that closes a frame.
   localparam logic [1:0]  SLOT_PRE    = 2'h2; // Slot before the last one.
   // Receive slot leads the counter by one: one output stage plus two
   // synchroniser stages make three cycles, which is minus one modulo four.
   localparam logic [1:0]  RX_LEAD     = 2'h1;

   // ==========================================================================
   // Buffering and values after reset
   // ==========================================================================
   localparam int          FIFO_DEPTH  = 8;
   localparam logic [1:0]  SLOT_RST    = 2'h0;
   localparam logic [15:0] WORD_RST    = 16'h0000;
   localparam logic [3:0]  NIB_RST     = 4'h0;

endpackage : anw_pkg

// >>> rtl/anw_nibble_link.sv
// Converter nibble link: transmit buffer, serializer and receive assembler.
`timescale 1ns/1ps

// ============================================================================
// Transmit word buffer
// ============================================================================
// Flags are kept in flip-flops so that ready and valid leave cleanly.
module anw_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output      logic             in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output      logic             out_valid_o,
   input  wire logic             out_ready_i,
   output      logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic [CW-1:0]    next_count;
   logic             push;
   logic             pop;

   // Handshakes and the occupancy that follows them.
   assign push       = in_valid_i && in_ready_o;
   assign pop        = out_valid_o && out_ready_i;
   assign next_count = count + CW'(push) - CW'(pop);
   assign out_data_o = mem[rd_ptr];

   // Storage is written without reset; pointers, count and flags carry control state.
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Write pointer wraps at the depth, which need not be a power of two.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
      end else if (push) begin
         wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
   end

   // Read pointer advances on every accepted word.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rd_ptr <= '0;
      end else if (pop) begin
         rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
   end

   // Count and registered full and empty flags.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         count       <= '0;
         in_ready_o  <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         count       <= next_count;
         in_ready_o  <= (next_count != CW'(DEPTH));
         out_valid_o <= (next_count != '0);
      end
   end

endmodule : anw_fifo

// ============================================================================
// Link top
// ============================================================================
// Operation
// - Each 16-bit transmit word leaves as four 4-bit slices on four cycles.
// - The word strobe is high in the first of the four cycles of a frame.
// - In slot k, transmit line i carries word bit 4k+i.
// - Transmit words come from the transmit front-end stage.
// - Each receive word is built from four slices sampled on four cycles.
// - In slot k, receive line i gives word bit 4k+i.
// - The word strobe recurs exactly every four clock cycles.
module anw_nibble_link
   import anw_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   // Transmit front-end stage.
   input  wire logic [WORD_W-1:0] tx_word_i,
   input  wire logic              tx_valid_i,
   output      logic              tx_ready_o,
   output      logic              tx_underrun_o,
   // Receive front-end stage.
   output      logic [WORD_W-1:0] rx_word_o,
   output      logic              rx_valid_o,
   // Converter pins.
   output      logic              word_strobe_o,
   output      logic [NIB_W-1:0]  afe_tx_nibble_o,
   input  wire logic [NIB_W-1:0]  afe_rx_nibble_i
);

   logic [SLOT_W-1:0] slot;
   logic [SLOT_W-1:0] rx_slot;
   logic [WORD_W-1:0] tx_word;
   logic [WORD_W-1:0] fifo_data;
   logic              fifo_valid;
   logic              tx_pop;
   logic [NIB_W-1:0]  rx_meta;
   logic [NIB_W-1:0]  rx_nib;
   logic [WORD_W-1:0] rx_acc;

   // ==========================================================================
   // Transmit buffer
   // ==========================================================================
   // The serializer drains one word per frame, so the buffer fills whenever
   // the front end runs ahead and its ready output pushes back.
   anw_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (DEPTH)
   ) u_tx_fifo (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .in_data_i   (tx_word_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (tx_pop),
      .out_data_o  (fifo_data)
   );

   // A word is taken only at the close of a frame.
   assign tx_pop = (slot == SLOT_LAST);

   // ==========================================================================
   // Frame timing
   // ==========================================================================
   // Free-running slot counter; the frame never stretches, even on underrun,
   // because the converter expects a sample every frame.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         slot <= SLOT_RST;
      end else begin
         slot <= slot + 1'b1;
      end
   end

   // Strobe is registered, so it is high while the pins carry slot 0.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         word_strobe_o <= 1'b0;
      end else begin
         word_strobe_o <= (slot == SLOT_FIRST);
      end
   end

   // ==========================================================================
   // Transmit serializer
   // ==========================================================================
   // The word is loaded at the close of a frame and held for the next four
   // cycles; an empty buffer sends a zero sample rather than a stale one.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         tx_word       <= WORD_RST;
         tx_underrun_o <= 1'b0;
      end else begin
         tx_underrun_o <= tx_pop && !fifo_valid;
         if (tx_pop) begin
            tx_word <= fifo_valid ? fifo_data : WORD_RST;
         end
      end
   end

   // Slice k of the held word goes out in slot k, low bits first.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         afe_tx_nibble_o <= NIB_RST;
      end else begin
         afe_tx_nibble_o <= tx_word[NIB_W*slot +: NIB_W];
      end
   end

   // ==========================================================================
   // Receive assembler
   // ==========================================================================
   // Pin levels are synchronised before use; the first stage feeds nothing
   // but the second. The fixed three-cycle lag is absorbed by the slot lead.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rx_meta <= NIB_RST;
         rx_nib  <= NIB_RST;
      end else begin
         rx_meta <= afe_rx_nibble_i;
         rx_nib  <= rx_meta;
      end
   end

   assign rx_slot = slot + RX_LEAD;

   // Slice k lands in bits 4k to 4k+3 of the word under construction.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rx_acc <= WORD_RST;
      end else begin
         rx_acc[NIB_W*rx_slot +: NIB_W] <= rx_nib;
      end
   end

   // The last slice bypasses the accumulator so the word leaves at once.
   // There is no ready: the converter cannot be stalled, so the receive
   // stage must take a word in every frame.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rx_word_o  <= WORD_RST;
         rx_valid_o <= 1'b0;
      end else begin
         rx_valid_o <= (rx_slot == SLOT_LAST);
         if (rx_slot == SLOT_LAST) begin
            rx_word_o <= {rx_nib, rx_acc[NIB_W*SLOT_LAST-1:0]};
         end
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   // Three quiet cycles between strobes.
   sequence s_quiet_frame;
      ##1 (!word_strobe_o) [*3] ##1 word_strobe_o;
   endsequence

   // The four slices of the held word, low slice first.
   sequence s_tx_slices;
      (afe_tx_nibble_o == $past(tx_word[3:0]))
      ##1 (afe_tx_nibble_o == $past(tx_word[7:4]))
      ##1 (afe_tx_nibble_o == $past(tx_word[11:8]))
      ##1 (afe_tx_nibble_o == $past(tx_word[15:12]));
   endsequence

   AST_STROBE_PERIOD: assert property (
      word_strobe_o |-> s_quiet_frame)
      else $error("word strobe period is not four cycles");

   AST_STROBE_SLOT: assert property (
      word_strobe_o |-> $past(slot) == SLOT_FIRST)
      else $error("word strobe not on the first slot");

   AST_TX_HOLD: assert property (
      word_strobe_o |-> ##1 (tx_word == $past(tx_word)) [*2])
      else $error("transmit word changed inside a frame");

   AST_TX_SLICES: assert property (
      word_strobe_o |-> s_tx_slices)
      else $error("transmit slice order wrong");

   AST_TX_SOURCE: assert property (
      (tx_pop && fifo_valid) |->
         ##2 (word_strobe_o && afe_tx_nibble_o == $past(fifo_data[3:0], 2)))
      else $error("transmit word not taken from the buffer");

   AST_RX_PERIOD: assert property (
      rx_valid_o |-> ##1 (!rx_valid_o) [*3] ##1 rx_valid_o)
      else $error("receive word period is not four cycles");

   AST_RX_BITS: assert property (
      rx_valid_o && $past(rx_valid_o, 4) |->
         rx_word_o == {$past(rx_nib, 1), $past(rx_nib, 2),
                       $past(rx_nib, 3), $past(rx_nib, 4)})
      else $error("receive word bits misplaced");

   AST_RX_DELIVER: assert property (
      word_strobe_o |-> ##2 rx_valid_o)
      else $error("receive word not delivered after last slice");

   // An empty buffer at the close of a frame must show up as a flagged
   // zero frame, never as a silent repeat of the word sent before.
   AST_UNDERRUN_FLAG: assert property (
      (tx_pop && !fifo_valid) |=> tx_underrun_o)
      else $error("underrun not flagged for an empty buffer");

   AST_UNDERRUN_ZERO: assert property (
      tx_underrun_o |-> ##1 (afe_tx_nibble_o == NIB_RST) [*4])
      else $error("underrun frame did not send a zero word");

   // The delivered word stands between pulses, so the receive stage may
   // pick it up late in the frame.
   AST_RX_HOLD: assert property (
      !rx_valid_o |-> $stable(rx_word_o))
      else $error("receive word changed between pulses");

   // Ready may only drop after an accepted word has filled the buffer.
   AST_TX_FULL_STOP: assert property (
      $fell(tx_ready_o) |-> $past(tx_valid_i && tx_ready_o))
      else $error("transmit ready dropped without a push");

endmodule : anw_nibble_link

// >>> tb/anw_afe_model.sv
// Behavioural converter: collects sent words and feeds receive slices.
`timescale 1ns/1ps

// ============================================================================
// Converter model
// ============================================================================
module anw_afe_model
   import anw_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              word_strobe_i,
   input  wire logic [NIB_W-1:0]  tx_nibble_i,
   output      logic [NIB_W-1:0]  rx_nibble_o,
   input  wire logic [WORD_W-1:0] rx_word_i,
   output      logic [WORD_W-1:0] got_word_o,
   output      logic              got_valid_o
);
   logic [1:0]        slot = 2'h0;
   logic [WORD_W-1:0] cur = '0;
   logic [WORD_W-1:0] part = '0;

   // Slice 0 comes straight from the next word so it meets the strobe cycle.
   always_comb begin
      if (word_strobe_i)
         rx_nibble_o = rx_word_i[3:0];
      else
         rx_nibble_o = cur[4*slot +: 4];
   end

   // The slot count realigns on every strobe; a word is out after slot 3.
   always_ff @(posedge sys_clk_i) begin
      got_valid_o <= !word_strobe_i && slot == 2'h3;
      if (word_strobe_i) begin
         slot      <= 2'h1;
         cur       <= rx_word_i;
         part[3:0] <= tx_nibble_i;
      end else begin
         slot              <= slot + 2'h1;
         part[4*slot +: 4] <= tx_nibble_i;
         if (slot == 2'h3) begin
            got_word_o <= {tx_nibble_i, part[11:0]};
         end
      end
   end
endmodule : anw_afe_model

// >>> tb/afe_nibble_word_interface_tb.sv
// Self-checking bench for the converter nibble link.
`timescale 1ns/1ps

// ============================================================================
// Bench top
// ============================================================================
module afe_nibble_word_interface_tb import anw_pkg::*;;
   typedef struct {logic [15:0] tx; logic [15:0] rx;} anw_row_s;
   anw_row_s rows[4] = '{'{16'h1234, 16'h8421}, '{16'hffff, 16'h0001},
                         '{16'h8001, 16'hfffe}, '{16'h5aa5, 16'ha55a}};
   logic              sys_clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic [WORD_W-1:0] tx_word_i = '0;
   logic              tx_valid_i = 1'b0;
   logic [WORD_W-1:0] rx_src = '0;
   logic              tx_ready_o, tx_underrun_o, rx_valid_o;
   logic              word_strobe_o, got_valid;
   logic [WORD_W-1:0] rx_word_o, got_word;
   logic [NIB_W-1:0]  afe_tx_nibble_o, afe_rx_nibble_i;
   int                n_fail = 0;
   int                num_checks = 0;
   int                n;
   int                base;
   int                n_got = 0;
   logic [WORD_W-1:0] got_log[32];

   anw_nibble_link u_anw_nibble_link (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .tx_word_i(tx_word_i), .tx_valid_i(tx_valid_i),
      .tx_ready_o(tx_ready_o), .tx_underrun_o(tx_underrun_o),
      .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o),
      .word_strobe_o(word_strobe_o), .afe_tx_nibble_o(afe_tx_nibble_o),
      .afe_rx_nibble_i(afe_rx_nibble_i));
   anw_afe_model u_anw_afe_model (.sys_clk_i(sys_clk_i),
      .word_strobe_i(word_strobe_o), .tx_nibble_i(afe_tx_nibble_o),
      .rx_nibble_o(afe_rx_nibble_i), .rx_word_i(rx_src),
      .got_word_o(got_word), .got_valid_o(got_valid));

   // Free-running clock at 8 ns.
   initial begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   // Arriving nonzero words are logged at once, up to 32, so a burst is never missed.
   always @(posedge sys_clk_i) begin
      if (got_valid === 1'b1 && got_word !== WORD_RST && n_got < 32) begin
         got_log[n_got] <= got_word;
         n_got          <= n_got + 1;
      end
   end

   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [WORD_W-1:0] got,
                      input logic [WORD_W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Sampling 1 ns after the edge sees registered outputs settled.
   task automatic wait_hi(ref logic sig, input logic nz);
      for (int i = 0; i < 40; i++) begin
         @(posedge sys_clk_i);
         #1;
         if (sig === 1'b1 && (!nz || got_word !== '0))
            return;
      end
      chk(1'b0, 1'b1);
      end_sim();
   endtask : wait_hi

   // Offers one word and holds it until an edge finds room.
   task automatic push(input logic [WORD_W-1:0] w);
      tx_word_i  <= w;
      tx_valid_i <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge sys_clk_i);
         if (tx_ready_o === 1'b1)
            return;
      end
      chk(1'b0, 1'b1);
      end_sim();
   endtask : push

   // Rows first, then reset, frame timing, a full buffer and underrun.
   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         @(posedge sys_clk_i);
         rx_src <= rows[i].rx;
         push(rows[i].tx);
         tx_valid_i <= 1'b0;
         wait_hi(got_valid, 1'b1);
         chk(got_word, rows[i].tx);
         repeat (3) wait_hi(rx_valid_o, 1'b0);
         chk(rx_word_o, rows[i].rx);
         $display("row %0d done", i);
      end
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk({word_strobe_o, tx_ready_o, rx_valid_o, tx_underrun_o,
           afe_tx_nibble_o}, {4'h0, NIB_RST});
      chk(rx_word_o, WORD_RST);
      @(posedge sys_clk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 9; k++) begin
         @(posedge sys_clk_i);
         #1;
         chk(word_strobe_o, k % 4 == 0);
         chk(rx_valid_o, k % 4 == 2);
         if (k == 0)
            chk(tx_ready_o, 1'b1);
         if (k == 3)
            chk(tx_underrun_o, 1'b1);
      end
      $display("reset and frame test done");
      @(posedge sys_clk_i);
      base = n_got;
      n = 0;
      for (int i = 0; i < 12; i++) begin
         tx_word_i  <= 16'h0100 + 16'(n);
         tx_valid_i <= 1'b1;
         @(posedge sys_clk_i);
         if (tx_ready_o === 1'b1)
            n++;
      end
      tx_valid_i <= 1'b0;
      chk(n >= 8 && n < 12, 1'b1);
      for (int i = 0; i < 200 && n_got < base + n; i++)
         @(posedge sys_clk_i);
      chk(n_got >= base + n, 1'b1);
      for (int j = 0; j < n; j++)
         chk(got_log[base + j], 16'h0100 + 16'(j));
      wait_hi(tx_underrun_o, 1'b0);
      $display("fill and drain test done");
      end_sim();
   end
endmodule : afe_nibble_word_interface_tb
